// ---- core/gpd_map.svh ----
// register map, field positions and reset values of the gpio data block
`ifndef GPD_MAP_SVH
`define GPD_MAP_SVH

`define GPD_ADDR_PORT0_SET   32'hFFFF_0D24
`define GPD_ADDR_PORT1_DAT   32'hFFFF_0D30
`define GPD_ADDR_PORT2_DAT   32'hFFFF_0D40

`define GPD_ZERO32           32'h0000_0000
`define GPD_P1_RW_MASK       32'h0303_0003
`define GPD_P2_RW_MASK       32'h7363_0073

`define GPD_BYTE_DIR         3
`define GPD_BYTE_OUT         2

`define GPD_P1_DIR_MSB       25
`define GPD_P1_DIR_LSB       24
`define GPD_P1_OUT_MSB       17
`define GPD_P1_OUT_LSB       16
`define GPD_P1_IN_MSB        1
`define GPD_P1_IN_LSB        0

`define GPD_P2_DIR6          30
`define GPD_P2_DIR5          29
`define GPD_P2_DIR4          28
`define GPD_P2_DIR1          25
`define GPD_P2_DIR0          24
`define GPD_P2_OUT6          22
`define GPD_P2_OUT5          21
`define GPD_P2_OUT1          17
`define GPD_P2_OUT0          16
`define GPD_P2_IN6           6
`define GPD_P2_IN5           5
`define GPD_P2_IN4           4
`define GPD_P2_IN1           1
`define GPD_P2_IN0           0

`define GPD_P0_SET_MSB       20
`define GPD_P0_SET_LSB       16

`define GPD_RESP_OKAY        2'h0
`define GPD_RESP_SLVERR      2'h2

`endif

// ---- core/gpd_pkg.sv ----
// types shared by the gpio data block
package gpd_pkg;
   // pin order of the five-pin vectors: 4 = pin6, 3 = pin5, 2 = pin4, 1 = pin1, 0 = pin0
   typedef struct packed {
      logic [1:0] dir;
      logic [1:0] out;
   } gpd_port1_s;

   // out holds pins {6, 5, 1, 0}; pin4 has no output bit
   typedef struct packed {
      logic [4:0] dir;
      logic [3:0] out;
   } gpd_port2_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } gpd_aw_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
      logic [3:0]  strb;
   } gpd_w_s;

   typedef enum logic {
      WR_IDLE,
      WR_RESP
   } gpd_wr_e;

   typedef enum logic {
      RD_IDLE,
      RD_DATA
   } gpd_rd_e;
endpackage

// ---- core/gpd_sync.sv ----
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module gpd_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // pins in, levels out
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         // s1 feeds only s2 so its metastability never reaches logic
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else begin
               s1 <= pin[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               level[i] <= 1'b0;
            end else if (s2 == s3) begin
               level[i] <= s3;
            end
         end
         sync_agree_a: assert property (@(posedge clk) disable iff (rst)
            (level[i] != $past(level[i])) |-> ($past(s2) == $past(s3)))
            else $error("level changed without stage agreement");
      end
   endgenerate
endmodule // gpd_sync

// ---- core/gpd_top.sv ----
// gpio data registers for the two-pin and five-pin ports, five-pin set register
// Functional notes
// - two-pin direction bits 25,24: 1 means output
// - two-pin bits 17,16 drive output pins directly
// - two-pin bits 1,0 read pin levels
// - five-pin direction bits 30,29,28,25,24
// - pin5 output enables high-voltage diagnostic write
// - pin4 input enables high-voltage diagnostic readback
// - five-pin bits 22,21,17,16 drive output pins
// - five-pin bits 6,5,1,0 read pin levels, bit 4 reads pin4 as output and the readback line as input
// - set register write-only, touches only chosen pins
// - upper bits reset zero, low byte follows pins
// - set bits 20..16: one sets, zero keeps
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gpd_map.svh"
module gpd_top
   import gpd_pkg::*;
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   // axi4-lite write address
   input  wire logic [31:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   // axi4-lite write data
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // axi4-lite read address
   input  wire logic [31:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   // axi4-lite read data
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // five-pin port outputs driven by the set register
   output logic [4:0]       PORT0_OUT,
   // two-pin port pins
   input  wire logic [1:0]  PORT1_IN,
   output logic [1:0]       PORT1_OUT,
   output logic [1:0]       PORT1_OE,
   // third port pins {6, 5, 4, 1, 0}
   input  wire logic [4:0]  PORT2_IN,
   output logic [4:0]       PORT2_OUT,
   output logic [4:0]       PORT2_OE,
   // high-voltage diagnostic paths
   output logic             HV_DIAG_WR_EN,
   output logic             HV_DIAG_WR_DATA,
   output logic             HV_DIAG_RD_EN,
   input  wire logic        HV_DIAG_RD_DATA
);

   gpd_aw_s     aw_hold;
   gpd_w_s      w_hold;
   gpd_wr_e     wr_state;
   gpd_rd_e     rd_state;
   gpd_port1_s  port1;
   gpd_port2_s  port2;
   logic [4:0]  port0_out;
   logic [1:0]  bresp;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic [7:0]  level;
   logic [4:0]  p2_level;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_p0;
   logic        wr_p1;
   logic        wr_p2;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   // pins and the readback line come from outside the clock domain
   gpd_sync #(
      .W(8)
   ) u_sync (
      .clk   (REF_CLK),
      .rst   (RST),
      .pin   ({HV_DIAG_RD_DATA, PORT2_IN, PORT1_IN}),
      .level (level)
   );

   // while pin4 is an input its bit shows the high-voltage readback line
   always_comb begin
      p2_level    = level[6:2];
      p2_level[2] = port2.dir[2] ? level[4] : level[7];
   end

   // write channel holding: address and data taken in either order
   assign S_AXI_AWREADY = !aw_hold.valid;
   assign S_AXI_WREADY  = !w_hold.valid;
   assign wr_fire       = aw_hold.valid && w_hold.valid && (wr_state == WR_IDLE);
   assign wr_p0         = wr_fire && (aw_hold.addr == `GPD_ADDR_PORT0_SET);
   assign wr_p1         = wr_fire && (aw_hold.addr == `GPD_ADDR_PORT1_DAT);
   assign wr_p2         = wr_fire && (aw_hold.addr == `GPD_ADDR_PORT2_DAT);

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         aw_hold <= '0;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_hold.valid <= 1'b1;
         aw_hold.addr  <= S_AXI_AWADDR;
      end else if (wr_fire) begin
         aw_hold.valid <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         w_hold <= '0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_hold.valid <= 1'b1;
         w_hold.data  <= S_AXI_WDATA;
         w_hold.strb  <= S_AXI_WSTRB;
      end else if (wr_fire) begin
         w_hold.valid <= 1'b0;
      end
   end

   // write response: one cycle after both halves are present
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wr_state <= WR_IDLE;
         bresp    <= `GPD_RESP_OKAY;
      end else begin
         case (wr_state)
            WR_IDLE: begin
               if (wr_fire) begin
                  wr_state <= WR_RESP;
                  bresp    <= (wr_p0 || wr_p1 || wr_p2) ? `GPD_RESP_OKAY : `GPD_RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (S_AXI_BREADY) begin
                  wr_state <= WR_IDLE;
               end
            end
            default: begin
               wr_state <= WR_IDLE;
            end
         endcase
      end
   end

   assign S_AXI_BVALID = (wr_state == WR_RESP);
   assign S_AXI_BRESP  = bresp;

   // reserved and level bits are simply dropped on write, no check is made
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         port1 <= '0;
      end else if (wr_p1) begin
         if (w_hold.strb[`GPD_BYTE_DIR]) begin
            port1.dir <= w_hold.data[`GPD_P1_DIR_MSB:`GPD_P1_DIR_LSB];
         end
         if (w_hold.strb[`GPD_BYTE_OUT]) begin
            port1.out <= w_hold.data[`GPD_P1_OUT_MSB:`GPD_P1_OUT_LSB];
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         port2 <= '0;
      end else if (wr_p2) begin
         if (w_hold.strb[`GPD_BYTE_DIR]) begin
            port2.dir <= {w_hold.data[`GPD_P2_DIR6], w_hold.data[`GPD_P2_DIR5],
                          w_hold.data[`GPD_P2_DIR4], w_hold.data[`GPD_P2_DIR1],
                          w_hold.data[`GPD_P2_DIR0]};
         end
         if (w_hold.strb[`GPD_BYTE_OUT]) begin
            port2.out <= {w_hold.data[`GPD_P2_OUT6], w_hold.data[`GPD_P2_OUT5],
                          w_hold.data[`GPD_P2_OUT1], w_hold.data[`GPD_P2_OUT0]};
         end
      end
   end

   // set-only: ones are or-ed in, so no read-modify-write is needed
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         port0_out <= '0;
      end else if (wr_p0 && w_hold.strb[`GPD_BYTE_OUT]) begin
         port0_out <= port0_out | w_hold.data[`GPD_P0_SET_MSB:`GPD_P0_SET_LSB];
      end
   end

   // pin drive straight from the register bits
   assign PORT0_OUT       = port0_out;
   assign PORT1_OUT       = port1.out;
   assign PORT1_OE        = port1.dir;
   assign PORT2_OUT       = {port2.out[3], port2.out[2], 1'b0, port2.out[1], port2.out[0]};
   assign PORT2_OE        = port2.dir;
   assign HV_DIAG_WR_EN   = port2.dir[3];
   assign HV_DIAG_WR_DATA = port2.out[2];
   assign HV_DIAG_RD_EN   = !port2.dir[2];

   // read mux; the set register is write-only and reads as zero
   always_comb begin
      next_rdata = `GPD_ZERO32;
      next_rresp = `GPD_RESP_OKAY;
      case (S_AXI_ARADDR)
         `GPD_ADDR_PORT0_SET: begin
            next_rdata = `GPD_ZERO32;
         end
         `GPD_ADDR_PORT1_DAT: begin
            next_rdata[`GPD_P1_DIR_MSB:`GPD_P1_DIR_LSB] = port1.dir;
            next_rdata[`GPD_P1_OUT_MSB:`GPD_P1_OUT_LSB] = port1.out;
            next_rdata[`GPD_P1_IN_MSB:`GPD_P1_IN_LSB]   = level[1:0];
         end
         `GPD_ADDR_PORT2_DAT: begin
            next_rdata[`GPD_P2_DIR6] = port2.dir[4];
            next_rdata[`GPD_P2_DIR5] = port2.dir[3];
            next_rdata[`GPD_P2_DIR4] = port2.dir[2];
            next_rdata[`GPD_P2_DIR1] = port2.dir[1];
            next_rdata[`GPD_P2_DIR0] = port2.dir[0];
            next_rdata[`GPD_P2_OUT6] = port2.out[3];
            next_rdata[`GPD_P2_OUT5] = port2.out[2];
            next_rdata[`GPD_P2_OUT1] = port2.out[1];
            next_rdata[`GPD_P2_OUT0] = port2.out[0];
            next_rdata[`GPD_P2_IN6]  = p2_level[4];
            next_rdata[`GPD_P2_IN5]  = p2_level[3];
            next_rdata[`GPD_P2_IN4]  = p2_level[2];
            next_rdata[`GPD_P2_IN1]  = p2_level[1];
            next_rdata[`GPD_P2_IN0]  = p2_level[0];
         end
         default: begin
            next_rresp = `GPD_RESP_SLVERR;
         end
      endcase
   end

   assign S_AXI_ARREADY = (rd_state == RD_IDLE);
   assign rd_fire       = S_AXI_ARVALID && S_AXI_ARREADY;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rd_state <= RD_IDLE;
         rdata    <= `GPD_ZERO32;
         rresp    <= `GPD_RESP_OKAY;
      end else begin
         case (rd_state)
            RD_IDLE: begin
               if (rd_fire) begin
                  rd_state <= RD_DATA;
                  rdata    <= next_rdata;
                  rresp    <= next_rresp;
               end
            end
            RD_DATA: begin
               if (S_AXI_RREADY) begin
                  rd_state <= RD_IDLE;
               end
            end
            default: begin
               rd_state <= RD_IDLE;
            end
         endcase
      end
   end

   assign S_AXI_RVALID = (rd_state == RD_DATA);
   assign S_AXI_RDATA  = rdata;
   assign S_AXI_RRESP  = rresp;

   p1_dir_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr_p1 && w_hold.strb[`GPD_BYTE_DIR])
      |=> (PORT1_OE == $past(w_hold.data[`GPD_P1_DIR_MSB:`GPD_P1_DIR_LSB])))
      else $error("two-pin direction not taken from write");

   p1_out_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr_p1 && w_hold.strb[`GPD_BYTE_OUT])
      |=> (PORT1_OUT == $past(w_hold.data[`GPD_P1_OUT_MSB:`GPD_P1_OUT_LSB])))
      else $error("two-pin output value not taken from write");

   p1_level_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (rd_fire && (S_AXI_ARADDR == `GPD_ADDR_PORT1_DAT))
      |=> (S_AXI_RDATA[`GPD_P1_IN_MSB:`GPD_P1_IN_LSB] == $past(level[1:0])))
      else $error("two-pin level bits wrong on read");

   p2_dir_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr_p2 && w_hold.strb[`GPD_BYTE_DIR])
      |=> (PORT2_OE[4] == $past(w_hold.data[`GPD_P2_DIR6]))
          && (PORT2_OE[2] == $past(w_hold.data[`GPD_P2_DIR4]))
          && (PORT2_OE[0] == $past(w_hold.data[`GPD_P2_DIR0])))
      else $error("third-port direction not taken from write");

   hv_write_path_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (HV_DIAG_WR_EN == PORT2_OE[3]) && (HV_DIAG_WR_DATA == PORT2_OUT[3]))
      else $error("diagnostic write path not tied to pin5");

   hv_read_path_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (rd_fire && (S_AXI_ARADDR == `GPD_ADDR_PORT2_DAT) && HV_DIAG_RD_EN)
      |=> (S_AXI_RDATA[`GPD_P2_IN4] == $past(level[7])))
      else $error("diagnostic readback not shown on pin4 bit");

   p2_out_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr_p2 && w_hold.strb[`GPD_BYTE_OUT])
      |=> (PORT2_OUT[3] == $past(w_hold.data[`GPD_P2_OUT5]))
          && (PORT2_OUT[1] == $past(w_hold.data[`GPD_P2_OUT1]))
          && (PORT2_OUT[2] == 1'b0))
      else $error("third-port output value not taken from write");

   p2_level_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (rd_fire && (S_AXI_ARADDR == `GPD_ADDR_PORT2_DAT))
      |=> (S_AXI_RDATA[`GPD_P2_IN6] == $past(level[6]))
          && (S_AXI_RDATA[`GPD_P2_IN0] == $past(level[2])))
      else $error("third-port level bits wrong on read");

   set_never_clears_a: assert property (@(posedge REF_CLK) disable iff (RST)
      ($past(port0_out) & ~port0_out) == 5'h00)
      else $error("set register cleared a pin");

   set_bits_high_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr_p0 && w_hold.strb[`GPD_BYTE_OUT])
      |=> (PORT0_OUT == ($past(port0_out)
                         | $past(w_hold.data[`GPD_P0_SET_MSB:`GPD_P0_SET_LSB]))))
      else $error("set register did not raise chosen pins");

   reserved_zero_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (rd_fire && (S_AXI_ARADDR == `GPD_ADDR_PORT1_DAT))
      |=> ((S_AXI_RDATA & ~`GPD_P1_RW_MASK) == `GPD_ZERO32))
      else $error("reserved bits not zero on read");

   resp_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (S_AXI_BVALID && !S_AXI_BREADY) |=> (S_AXI_BVALID && $stable(S_AXI_BRESP)))
      else $error("write response dropped before taken");

endmodule // gpd_top

// ---- verification/gpd_pins.sv ----
// external pin and high-voltage readback model facing the gpio data block
`timescale 1ns/1ps
module gpd_pins (
   // block side
   input  wire logic [1:0] p1_oe,
   input  wire logic [1:0] p1_out,
   input  wire logic [4:0] p2_oe,
   input  wire logic [4:0] p2_out,
   input  wire logic       hv_rd_en,
   // outside levels
   input  wire logic [1:0] p1_ext,
   input  wire logic [4:0] p2_ext,
   input  wire logic       hv_ext,
   // levels seen by the block
   output logic      [1:0] p1_in,
   output logic      [4:0] p2_in,
   output logic            hv_rd
);
   // a driven pin shows the block's value, an undriven one the outside level
   assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1_ext);
   assign p2_in = (p2_oe & p2_out) | (~p2_oe & p2_ext);
   // readback not enabled: inverse level, so a stale value cannot pass
   assign hv_rd = hv_rd_en ? hv_ext : ~hv_ext;
endmodule // gpd_pins

// ---- verification/test_gpio_port_data_and_set.sv ----
// self-checking bench for the gpio data block
`timescale 1ns/1ps
`include "gpd_map.svh"
module test_gpio_port_data_and_set;
   import gpd_pkg::*;
   typedef struct {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0]  ext1;
      logic [4:0]  ext2;
      logic        hv;
      logic [31:0] rd;
      logic [1:0]  resp;
      logic [6:0]  oe;
      logic [6:0]  out;
      logic [2:0]  hx;
      logic [4:0]  p0;
   } gpd_row_s;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] awaddr = 32'h0000_0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] araddr = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   logic [3:0]  strb_sel = 4'hF;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [1:0]  p1_ext = 2'h0;
   logic [4:0]  p2_ext = 5'h00;
   logic        hv_ext = 1'b0;
   wire  [31:0] rdata;
   wire  [1:0]  bresp, rresp, p1_oe, p1_out, p1_in;
   wire         awready, wready, bvalid, arready, rvalid, hv_wr_en, hv_wr_data, hv_rd_en, hv_rd;
   wire  [4:0]  p0_out, p2_oe, p2_out, p2_in;
   wire  [6:0]  oe_v = {p2_oe, p1_oe};
   wire  [6:0]  out_v = {p2_out, p1_out} & {p2_oe, p1_oe};
   wire  [2:0]  hx_v = {hv_wr_en, hv_wr_en & hv_wr_data, hv_rd_en};
   int          err_total = 0;
   int          cmp_count = 0;
   gpd_row_s    rows [8];
   gpd_row_s    r;
   logic [31:0] got;
   logic [1:0]  resp;

   gpd_top gpd_top_i (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .PORT0_OUT(p0_out), .PORT1_IN(p1_in), .PORT1_OUT(p1_out), .PORT1_OE(p1_oe),
      .PORT2_IN(p2_in), .PORT2_OUT(p2_out), .PORT2_OE(p2_oe), .HV_DIAG_WR_EN(hv_wr_en),
      .HV_DIAG_WR_DATA(hv_wr_data), .HV_DIAG_RD_EN(hv_rd_en), .HV_DIAG_RD_DATA(hv_rd));
   gpd_pins gpd_pins_i (.p1_oe(p1_oe), .p1_out(p1_out), .p2_oe(p2_oe), .p2_out(p2_out),
      .hv_rd_en(hv_rd_en), .p1_ext(p1_ext), .p2_ext(p2_ext), .hv_ext(hv_ext), .p1_in(p1_in),
      .p2_in(p2_in), .hv_rd(hv_rd));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
      int   n;
      logic aw_p, w_p;
      n = 0;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= strb_sel;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (aw_p && awready === 1'b1) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready === 1'b1) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1 && n < 40);
      rs = bresp;
      bready <= 1'b0;
      check(32'(bvalid), 32'h0000_0001);
   endtask

   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
      int   n;
      logic ar_p;
      n = 0;
      ar_p = 1'b1;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (ar_p && arready === 1'b1) begin
            ar_p = 1'b0;
            arvalid <= 1'b0;
         end
      end while (rvalid !== 1'b1 && n < 40);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
      check(32'(rvalid), 32'h0000_0001);
   endtask

   // low byte follows the pins, so only the upper bits are fixed after reset
   task automatic reset_check(input string name);
      repeat (6) @(posedge clk);
      check(32'(oe_v), 32'h0000_0000);
      check(32'(p0_out), 32'h0000_0000);
      check(32'(hx_v), 32'h0000_0001);
      axi_read(`GPD_ADDR_PORT1_DAT, got, resp);
      check(got & 32'hFFFF_FF00, 32'h0000_0000);
      axi_read(`GPD_ADDR_PORT2_DAT, got, resp);
      check(got & 32'hFFFF_FF00, 32'h0000_0000);
      $display("test %s done", name);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #50000;
      err_total++;
      complete_run;
   end

   initial begin
      rows[0] = '{32'hFFFF_0D30, 32'h0000_0000, 2'h2, 5'h00, 1'b0, 32'h0000_0002, 2'h0, 7'h00,
                  7'h00, 3'h1, 5'h00};
      rows[1] = '{32'hFFFF_0D30, 32'h0303_0000, 2'h0, 5'h00, 1'b0, 32'h0303_0003, 2'h0, 7'h03,
                  7'h03, 3'h1, 5'h00};
      rows[2] = '{32'hFFFF_0D30, 32'h0102_0000, 2'h3, 5'h00, 1'b0, 32'h0102_0002, 2'h0, 7'h01,
                  7'h00, 3'h1, 5'h00};
      rows[3] = '{32'hFFFF_0D40, 32'h0000_0000, 2'h3, 5'h15, 1'b0, 32'h0000_0041, 2'h0, 7'h01,
                  7'h00, 3'h1, 5'h00};
      rows[4] = '{32'hFFFF_0D40, 32'h7063_0000, 2'h3, 5'h00, 1'b1, 32'h7063_0060, 2'h0, 7'h71,
                  7'h60, 3'h6, 5'h00};
      rows[5] = '{32'hFFFF_0D40, 32'h0320_0000, 2'h3, 5'h0B, 1'b1, 32'h0320_0030, 2'h0, 7'h0D,
                  7'h00, 3'h1, 5'h00};
      rows[6] = '{32'hFFFF_0D24, 32'h0005_0000, 2'h3, 5'h0B, 1'b1, 32'h0000_0000, 2'h0, 7'h0D,
                  7'h00, 3'h1, 5'h05};
      rows[7] = '{32'hFFFF_0D20, 32'hFFFF_FFFF, 2'h3, 5'h0B, 1'b1, 32'h0000_0000, 2'h2, 7'h0D,
                  7'h00, 3'h1, 5'h05};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      reset_check("first reset");
      for (int i = 0; i < 8; i++) begin
         r = rows[i];
         @(posedge clk);
         p1_ext <= r.ext1;
         p2_ext <= r.ext2;
         hv_ext <= r.hv;
         axi_write(r.addr, r.wdata, resp);
         check(32'(resp), 32'(r.resp));
         repeat (6) @(posedge clk);
         axi_read(r.addr, got, resp);
         check(got, r.rd);
         check(32'(resp), 32'(r.resp));
         check(32'(oe_v), 32'(r.oe));
         check(32'(out_v), 32'(r.out));
         check(32'(hx_v), 32'(r.hx));
         check(32'(p0_out), 32'(r.p0));
         $display("test row %0d done", i);
      end
      // zero bits keep earlier set pins, other ports untouched
      axi_write(`GPD_ADDR_PORT0_SET, 32'h0000_0000, resp);
      repeat (2) @(posedge clk);
      check(32'(p0_out), 32'h0000_0005);
      axi_write(`GPD_ADDR_PORT0_SET, 32'h0012_0000, resp);
      repeat (2) @(posedge clk);
      check(32'(p0_out), 32'h0000_0017);
      check(32'(oe_v), 32'h0000_000D);
      $display("test set register done");
      // a pin change must not reach a read issued at once
      @(posedge clk);
      p1_ext <= 2'h0;
      axi_read(`GPD_ADDR_PORT1_DAT, got, resp);
      check(got, 32'h0102_0002);
      repeat (6) @(posedge clk);
      axi_read(`GPD_ADDR_PORT1_DAT, got, resp);
      check(got, 32'h0102_0000);
      $display("test synchroniser done");
      // one byte lane alone changes only its own field
      strb_sel = 4'h4;
      axi_write(`GPD_ADDR_PORT1_DAT, 32'h0303_0000, resp);
      repeat (6) @(posedge clk);
      axi_read(`GPD_ADDR_PORT1_DAT, got, resp);
      check(got, 32'h0103_0001);
      strb_sel = 4'h8;
      axi_write(`GPD_ADDR_PORT1_DAT, 32'h0200_0000, resp);
      repeat (6) @(posedge clk);
      axi_read(`GPD_ADDR_PORT1_DAT, got, resp);
      check(got, 32'h0203_0002);
      check(32'(out_v), 32'h0000_0002);
      strb_sel = 4'hF;
      $display("test byte lanes done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      reset_check("second reset");
      complete_run;
   end
endmodule // test_gpio_port_data_and_set
